/* File: verilog/serial_power_host_defines.svh */
// Register map, field positions, reset values and widths of the power host
`ifndef SERIAL_POWER_HOST_DEFINES_SVH
`define SERIAL_POWER_HOST_DEFINES_SVH

`define SPH_ADR_W 4
`define SPH_CTRL_OFS 4'h0
`define SPH_TXD_OFS 4'h4
`define SPH_STAT_OFS 4'h8

`define SPH_CTRL_SLEEP 0
`define SPH_CTRL_AUTO 1
`define SPH_CTRL_RXDIS 2
`define SPH_CTRL_PEER 3
`define SPH_CTRL_LOWPWR 4
`define SPH_CTRL_USED_LO 5
`define SPH_CTRL_USED_HI 7
`define SPH_CTRL_RST 8'h00
`define SPH_PINS_RST 7'h70

`define SPH_TX_N 3
`define SPH_RX_N 5
`define SPH_MON_N 2
`define SPH_SYNC_W 8

`define SPH_STAT_SIG 0
`define SPH_STAT_MODE_LO 1
`define SPH_STAT_MODE_HI 2
`define SPH_STAT_RX_LO 3
`define SPH_STAT_RX_HI 7
`define SPH_STAT_MON_LO 8
`define SPH_STAT_MON_HI 9

`endif

/* File: verilog/serial_power_host_pkg.sv */
// Types shared by the serial transceiver power host
package serial_power_host_pkg;

  typedef enum logic [1:0] {
    M_ACTIVE,
    M_MANUAL,
    M_AUTO
  } mode_t;

  typedef struct packed {
    logic [2:0] tx_used;
    logic low_power;
    logic peer_off;
    logic rx_dis;
    logic auto_en;
    logic sleep;
  } ctrl_t;

  typedef struct packed {
    logic manual_sleep_n;
    logic force_sleep_n;
    logic auto_sleep_inhibit;
    logic rx_disable;
    logic [2:0] tx_in;
  } pins_t;

  typedef struct packed {
    logic sig_present;
    logic [4:0] rx_out;
    logic [1:0] monitor_rx_out;
  } sense_t;

endpackage

/* File: verilog/serial_power_host.sv */
// Host controller driving the mode pins and data inputs of a serial transceiver
`timescale 1ns/1ns
`default_nettype none
`include "serial_power_host_defines.svh"

// Summary of operation
// RULE1: Device inverts each transmitter logic input
// RULE2: Device floats transmitter outputs in powerdown
// RULE3: Device stops charge pump in powerdown
// RULE4: Charge pump runs only while rails sag
// RULE5: Transmit path carries at least 250kbps
// RULE6: Standard receivers invert and can three-state
// RULE7: Monitor receivers pass non-inverted, always driven
// RULE8: Receiver disable input high floats receivers
// RULE9: Forced sleep disables receivers, auto does not
// RULE10: Monitor receivers keep working in manual sleep
// RULE11: Disable receivers feeding a powered-down peripheral
// RULE12: Shutdown pin high runs, low sleeps
// RULE13: Keep shutdown pin high when unused
// RULE14: Receivers stay on; disable them for low power
// RULE15: Both force pins high means always on
// RULE16: Force-off low sleeps, dominating force-on
// RULE17: Force-on high disables automatic powerdown
// RULE18: Tie unused transmitter inputs low
// RULE19: Signal-present drops when no valid line levels
// RULE20: Valid levels raise signal-present and wake device
// RULE21: No signal with auto enabled means auto sleep
// RULE22: Mode decode from controls and signal-present

module serial_power_host (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`SPH_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output serial_power_host_pkg::pins_t pins_o,
  input wire serial_power_host_pkg::sense_t sense_i
);
  import serial_power_host_pkg::*;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [`SPH_ADR_W-1:0] a, input logic [`SPH_ADR_W-1:0] o);
    hit = (a == o);
  endfunction

  // ------------------------------------------------------------
  // Pin input synchronisers
  // ------------------------------------------------------------
  sense_t sync1_r;
  sense_t sense_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sense_r <= '0;
    end else begin
      sync1_r <= sense_i;
      sense_r <= sync1_r;
    end
  end

  // ------------------------------------------------------------
  // Registers and bus slave
  // ------------------------------------------------------------
  ctrl_t ctrl_r;
  ctrl_t ctrl_nxt;
  logic [2:0] txd_r;
  logic [2:0] txd_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  mode_t mode_r;
  mode_t mode_nxt;
  logic req;

  assign req = cyc_i && stb_i && !ack_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    txd_nxt = txd_r;
    dat_nxt = dat_r;
    ack_nxt = req;
    if (req && we_i && sel_i[0]) begin
      if (hit(adr_i, `SPH_CTRL_OFS)) begin
        ctrl_nxt.sleep = dat_i[`SPH_CTRL_SLEEP];
        ctrl_nxt.auto_en = dat_i[`SPH_CTRL_AUTO];
        ctrl_nxt.rx_dis = dat_i[`SPH_CTRL_RXDIS];
        ctrl_nxt.peer_off = dat_i[`SPH_CTRL_PEER];
        ctrl_nxt.low_power = dat_i[`SPH_CTRL_LOWPWR];
        ctrl_nxt.tx_used = dat_i[`SPH_CTRL_USED_HI:`SPH_CTRL_USED_LO];
      end
      if (hit(adr_i, `SPH_TXD_OFS)) begin
        txd_nxt = dat_i[`SPH_TX_N-1:0];
      end
    end
    if (req && !we_i) begin
      dat_nxt = 32'h0;
      if (hit(adr_i, `SPH_CTRL_OFS)) begin
        dat_nxt[7:0] = ctrl_r;
      end
      if (hit(adr_i, `SPH_TXD_OFS)) begin
        dat_nxt[`SPH_TX_N-1:0] = txd_r;
      end
      if (hit(adr_i, `SPH_STAT_OFS)) begin
        dat_nxt[`SPH_STAT_SIG] = sense_r.sig_present;
        dat_nxt[`SPH_STAT_MODE_HI:`SPH_STAT_MODE_LO] = mode_r;
        dat_nxt[`SPH_STAT_RX_HI:`SPH_STAT_RX_LO] = sense_r.rx_out;
        dat_nxt[`SPH_STAT_MON_HI:`SPH_STAT_MON_LO] = sense_r.monitor_rx_out;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `SPH_CTRL_RST;
      txd_r <= 3'h0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      txd_r <= txd_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ------------------------------------------------------------
  // Pin drive and device mode tracking
  // ------------------------------------------------------------
  pins_t pins_r;
  pins_t pins_nxt;

  always_comb begin
    pins_nxt.manual_sleep_n = !ctrl_r.sleep; // RULE12 RULE13
    pins_nxt.force_sleep_n = !ctrl_r.sleep; // RULE15 RULE16
    pins_nxt.auto_sleep_inhibit = !ctrl_r.auto_en; // RULE17 RULE15
    pins_nxt.rx_disable = ctrl_r.rx_dis || ctrl_r.peer_off // RULE11 RULE8
      || (ctrl_r.sleep && ctrl_r.low_power); // RULE14
    pins_nxt.tx_in = txd_r & ctrl_r.tx_used; // RULE18 RULE1
    if (ctrl_r.sleep) begin
      mode_nxt = M_MANUAL; // RULE16 RULE22
    end else if (ctrl_r.auto_en && !sense_r.sig_present) begin
      mode_nxt = M_AUTO; // RULE19 RULE21
    end else begin
      mode_nxt = M_ACTIVE; // RULE20
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_r <= `SPH_PINS_RST;
      mode_r <= M_ACTIVE;
    end else begin
      pins_r <= pins_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign pins_o = pins_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence bus_ans;
    ack_o ##1 !ack_o;
  endsequence

  bus_ack_a: assert property (bus_req |=> bus_ans)
    else $error("bus ack not a single pulse");
  sleep_pins_a: assert property (ctrl_r.sleep |=> !pins_o.force_sleep_n && !pins_o.manual_sleep_n) // RULE16
    else $error("sleep request not driven low");
  awake_pins_a: assert property (!ctrl_r.sleep |=> pins_o.force_sleep_n && pins_o.manual_sleep_n) // RULE12
    else $error("awake not driven high");
  auto_inhibit_a: assert property (!ctrl_r.auto_en |=> pins_o.auto_sleep_inhibit) // RULE17
    else $error("auto sleep not inhibited");
  peer_rx_a: assert property (ctrl_r.peer_off |=> pins_o.rx_disable) // RULE11
    else $error("receivers left on into dead peer");
  sleep_rx_a: assert property (ctrl_r.sleep && ctrl_r.low_power |=> pins_o.rx_disable) // RULE14
    else $error("receivers left on in low power sleep");
  tx_tie_a: assert property (##1 (pins_o.tx_in & ~$past(ctrl_r.tx_used)) == 3'h0) // RULE18
    else $error("unused transmitter input not low");
  auto_mode_a: assert property (!ctrl_r.sleep && ctrl_r.auto_en && !sense_r.sig_present
    |=> mode_r == M_AUTO) // RULE21
    else $error("auto sleep not tracked");
  wake_mode_a: assert property (mode_r == M_AUTO && sense_r.sig_present && !ctrl_r.sleep
    |=> mode_r == M_ACTIVE) // RULE20
    else $error("wake not tracked");
  write_ctrl_a: assert property (bus_req ##0 we_i && sel_i[0] && adr_i == `SPH_CTRL_OFS
    |=> ctrl_r.sleep == $past(dat_i[`SPH_CTRL_SLEEP])) // RULE22
    else $error("control write lost");
  manual_mode_a: assert property (ctrl_r.sleep |=> mode_r == M_MANUAL) // RULE16
    else $error("manual sleep not tracked");
  rx_dis_a: assert property (ctrl_r.rx_dis |=> pins_o.rx_disable) // RULE8
    else $error("receiver disable not driven");
  auto_allow_a: assert property (ctrl_r.auto_en |=> !pins_o.auto_sleep_inhibit) // RULE17
    else $error("auto sleep wrongly inhibited");
  active_mode_a: assert property (!ctrl_r.sleep && !ctrl_r.auto_en |=> mode_r == M_ACTIVE) // RULE15
    else $error("always on not tracked");
  write_txd_a: assert property (bus_req ##0 we_i && sel_i[0] && adr_i == `SPH_TXD_OFS // RULE18
    |=> txd_r == $past(dat_i[`SPH_TX_N-1:0]))
    else $error("transmit data write lost");
  read_stat_a: assert property (bus_req ##0 !we_i && adr_i == `SPH_STAT_OFS // RULE19
    |=> dat_o[`SPH_STAT_SIG] == $past(sense_r.sig_present))
    else $error("signal present not reported");

endmodule // serial_power_host
`default_nettype wire

/* File: tb/xcvr_model.sv */
// Behavioural model of the serial transceiver facing the host
`timescale 1ns/1ns
`default_nettype none
module xcvr_model (
  input wire serial_power_host_pkg::pins_t pins,
  input wire logic line_valid,
  input wire logic [4:0] line_data,
  output serial_power_host_pkg::sense_t sense,
  output logic [2:0] tx_out,
  output logic pump_on
);
  import serial_power_host_pkg::*;
  logic down;
  logic rx_en;
  assign down = !pins.force_sleep_n || !pins.manual_sleep_n
    || (!pins.auto_sleep_inhibit && !line_valid);
  assign rx_en = !pins.rx_disable && pins.force_sleep_n;
  assign tx_out = down ? 3'hz : ~pins.tx_in;
  assign pump_on = !down;
  assign sense.sig_present = line_valid;
  // Floating receiver outputs pulled up
  assign sense.rx_out = rx_en ? ~line_data : 5'h1f;
  assign sense.monitor_rx_out = line_data[1:0];
endmodule // xcvr_model
`default_nettype wire

/* File: tb/serial_power_host_tb.sv */
// Self-checking bench for the serial transceiver power host
`timescale 1ns/1ns
`default_nettype none
`include "serial_power_host_defines.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module serial_power_host_tb;
  import serial_power_host_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  pins_t pins_o;
  sense_t sense_i;
  logic line_valid = 1'b1;
  logic [4:0] line_data = 5'h05;
  logic [2:0] tx_out;
  logic pump_on;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;
  always #20 ref_clk = ~ref_clk;
  serial_power_host u_serial_power_host (.ref_clk(ref_clk), .nrst(nrst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pins_o(pins_o), .sense_i(sense_i));
  xcvr_model u_xcvr_model (.pins(pins_o), .line_valid(line_valid), .line_data(line_data),
    .sense(sense_i), .tx_out(tx_out), .pump_on(pump_on));
  // ----------------------------------------
  // Verdict and bus tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int i;
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge ref_clk);
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic st(input string nm, input logic [1:0] m, input logic [4:0] rx);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, `SPH_STAT_OFS, 32'h0, 4'hf);
    `CHK(nm, {22'h0, line_data[1:0], rx, m, line_valid}, rd)
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    `CHK("pins_rst", `SPH_PINS_RST, pins_o)
    bus(1'b0, `SPH_CTRL_OFS, 32'h0, 4'hf);
    `CHK("ctrl_rst", 8'h00, rd[7:0])
    wr(`SPH_CTRL_OFS, 32'he0);
    wr(`SPH_TXD_OFS, 32'h5);
    `CHK("tx_out", 3'h2, tx_out)
    st("st_act", 2'h0, 5'h1a);
    wr(`SPH_CTRL_OFS, 32'h60);
    `CHK("tx_mask", 3'h1, pins_o.tx_in)
    wr(`SPH_CTRL_OFS, 32'h01);
    `CHK("sleep_pins", 2'h0, {pins_o.manual_sleep_n, pins_o.force_sleep_n})
    `CHK("tx_float", 3'hz, tx_out)
    `CHK("pump", 1'b0, pump_on)
    st("st_man", 2'h1, 5'h1f);
    wr(`SPH_CTRL_OFS, 32'h11);
    `CHK("lowpwr", 1'b1, pins_o.rx_disable)
    wr(`SPH_CTRL_OFS, 32'h02);
    `CHK("inhibit", 1'b0, pins_o.auto_sleep_inhibit)
    line_valid <= 1'b0;
    st("st_auto", 2'h2, 5'h1a);
    line_valid <= 1'b1;
    st("st_wake", 2'h0, 5'h1a);
    wr(`SPH_CTRL_OFS, 32'h04);
    `CHK("rxdis", 1'b1, pins_o.rx_disable)
    st("st_rxdis", 2'h0, 5'h1f);
    wr(`SPH_CTRL_OFS, 32'h08);
    `CHK("peer", 1'b1, pins_o.rx_disable)
    bus(1'b1, `SPH_CTRL_OFS, 32'h01, 4'he);
    bus(1'b0, `SPH_CTRL_OFS, 32'h0, 4'hf);
    `CHK("sel_ign", 8'h08, rd[7:0])
    bus(1'b1, 4'hc, 32'hff, 4'hf);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, rd)
    print_verdict();
  end
endmodule // serial_power_host_tb
`default_nettype wire
